// [rtl/dfm_defines.vh]
// Constants for the drive fault monitor
`ifndef DFM_DEFINES_VH
`define DFM_DEFINES_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define DFM_OFS_CTRL     8'h00
`define DFM_OFS_ULWDLY   8'h04
`define DFM_OFS_ULTDLY   8'h08
`define DFM_OFS_ULLVL    8'h0c
`define DFM_OFS_OVSPD    8'h10
`define DFM_OFS_SPDDEV   8'h14
`define DFM_OFS_ENCBRK   8'h18
`define DFM_OFS_OUTSEL   8'h1c
`define DFM_OFS_FREQ     8'h20
`define DFM_OFS_STATUS   8'h24
`define DFM_OFS_MASK     8'h28
`define DFM_OFS_TRIP     8'h2c
// ----------------------------------------
// Reset values (times in 10 ms ticks)
// ----------------------------------------
`define DFM_RST_CTRL     32'h0010_0019
`define DFM_RST_ULWDLY   16'h03e8
`define DFM_RST_ULTDLY   16'h0bb8
`define DFM_RST_ULLVL    16'h1e1e
`define DFM_RST_OVSPD    32'h0001_2ee0
`define DFM_RST_SPDDEV   32'h0064_07d0
`define DFM_RST_ENCBRK   32'h000a_0064
`define DFM_RST_OUTSEL   24'h1f_08_06
`define DFM_RST_FREQ     32'h00c8_1770
// ----------------------------------------
// Field positions and codes
// ----------------------------------------
`define DFM_CTRL_ULW_EN  0
`define DFM_CTRL_DUTY    1
`define DFM_CTRL_ESAVE   2
`define DFM_CTRL_DEV_EN  3
`define DFM_CTRL_ENC_EN  4
`define DFM_CTRL_FAN     5
`define DFM_MODE_SL2     3'h3
`define DFM_MODE_VECTOR  3'h4
`define DFM_UL_COAST     2'h1
`define DFM_UL_DECEL     2'h2
`define DFM_SEL_UL       5'h06
`define DFM_SEL_FAN      5'h08
`define DFM_SEL_DBW      5'h1f
`define DFM_TRIP_UL      4'h1
`define DFM_TRIP_OVSPD   4'h2
`define DFM_TRIP_DEV     4'h3
`define DFM_TRIP_ENC     4'h4
`define DFM_TRIP_FAN     4'h5
`define DFM_DUTY_MAX     8'h1e
`define DFM_LF_MIN       8'h0a
`define DFM_LF_MAX       8'h1e
`define DFM_BF_MIN       8'h0a
`define DFM_BF_MAX       8'h64
`define DFM_DLY_MAX      16'hea60
// ----------------------------------------
// Timing
// ----------------------------------------
`define DFM_CLK_NS       50
`define DFM_TICK_MS      10
`define DFM_TICK_CYCLES  18'd200000
`define DFM_BRAKE_MAX_S  15
`define DFM_BRAKE_TICKS  16'd1500
`endif

// [rtl/dfm_monitor.v]
// Drive fault monitor: braking limiter, load, speed, encoder and fan protection
//
// Function
// - Continuous braking is cut off once it has lasted fifteen seconds.
// - Braking duty is deceleration time over whole cycle time, in percent.
// - Duty limit defaults to 10, ranges 0 to 30, and is output code 31.
// - Underload trip action 1 blocks output, action 2 decelerates to stop.
// - With warning enabled, an output set to code 6 shows the underload state.
// - Underload acts after its warning or trip delay, each 0 to 600 s.
// - Underload detection is off while energy saving is on.
// - The low and base frequency levels set the underload threshold.
// - Load duty 0 is normal duty and 1 is heavy duty threshold profile.
// - In sensorless-2 or vector mode, persistent overspeed blocks output.
// - In vector mode with deviation trip on, persistent deviation blocks output.
// - Encoder checks run only while the encoder module is present.
// - A lost encoder line for the check time raises an encoder trip.
// - Fan mode 0 trips on fan error, mode 1 only warns on output code 8.
`timescale 1ns/1ps
`default_nettype none
`include "dfm_defines.vh"

module dfm_monitor #(
  parameter [17:0] TICK_CYCLES = `DFM_TICK_CYCLES
) (
  // Clock, reset, enable
  input  wire        CLK,
  input  wire        RESET,
  input  wire        CE,
  // AXI4-Lite slave
  input  wire [7:0]  S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output reg         S_AXI_AWREADY,
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output reg         S_AXI_WREADY,
  output reg  [1:0]  S_AXI_BRESP,
  output reg         S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  input  wire [7:0]  S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output reg         S_AXI_ARREADY,
  output reg  [31:0] S_AXI_RDATA,
  output reg  [1:0]  S_AXI_RRESP,
  output reg         S_AXI_RVALID,
  input  wire        S_AXI_RREADY,
  // Drive measurements (same clock)
  input  wire [15:0] SPEED_MEAS,
  input  wire [15:0] SPEED_REF,
  input  wire [7:0]  LOAD_LEVEL,
  input  wire [1:0]  RUN_PHASE,
  input  wire        BRAKE_REQ,
  // Pins from outside
  input  wire        ENC_LINE_OK,
  input  wire        ENC_MODULE,
  input  wire        FAN_ERROR,
  // Protection outputs
  output reg         BRAKE_OUT,
  output reg         OUT_BLOCK,
  output reg         DECEL_STOP,
  output reg  [3:0]  TRIP_CODE,
  output reg         RELAY1,
  output reg         RELAY2,
  output reg         OC_Q1,
  output reg         IRQ
);

  localparam [1:0] PH_STOP = 2'h0;
  localparam [1:0] PH_ACC  = 2'h1;
  localparam [1:0] PH_DEC  = 2'h3;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Persistence step, clears when the condition drops
  function [15:0] persist;
    input        cond;
    input        tick;
    input [15:0] cnt;
    begin
      if (!cond)
        persist = 16'h0000;
      else if (tick && cnt != 16'hffff)
        persist = cnt + 16'h0001;
      else
        persist = cnt;
    end
  endfunction

  // Clamp a byte field into its legal range
  function [7:0] clamp8;
    input [7:0] v;
    input [7:0] lo;
    input [7:0] hi;
    begin
      clamp8 = (v < lo) ? lo : ((v > hi) ? hi : v);
    end
  endfunction

  // Relay and open-collector function select
  function sel_out;
    input [4:0] sel;
    input       ulw;
    input       fanw;
    input       dbw;
    begin
      case (sel)
        `DFM_SEL_UL:  sel_out = ulw;
        `DFM_SEL_FAN: sel_out = fanw;
        `DFM_SEL_DBW: sel_out = dbw;
        default:      sel_out = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  reg [31:0] ctrl_reg;
  reg [15:0] ulw_dly_reg, ult_dly_reg, ul_lvl_reg;
  reg [31:0] ovspd_reg, spddev_reg, encbrk_reg, freq_reg;
  reg [23:0] outsel_reg;
  reg [4:0]  status_reg, mask_reg;
  reg [17:0] tick_cnt_reg;
  reg        tick_reg;
  reg [1:0]  enc_ok_s_reg, enc_mod_s_reg, fan_s_reg;
  reg [15:0] ulw_cnt_reg, ult_cnt_reg, ovs_cnt_reg, dev_cnt_reg, enc_cnt_reg;
  reg [15:0] brk_cnt_reg, dec_cnt_reg, tot_cnt_reg;
  reg [23:0] num_reg, den_reg;
  reg [7:0]  pct_reg, duty_reg;
  reg        div_busy_reg, dbw_reg, ulw_reg, brk_cut_reg;
  reg [1:0]  phase_prev_reg;
  reg        aw_ok_reg, w_ok_reg;
  reg [7:0]  aw_addr_reg;
  reg [31:0] wdata_reg;
  reg [3:0]  wstrb_reg;

  // Decoded configuration
  wire [2:0]  mode      = ctrl_reg[10:8];
  wire [1:0]  ul_action = ctrl_reg[21:20];
  wire [7:0]  lf_lvl    = clamp8(ul_lvl_reg[7:0], `DFM_LF_MIN, `DFM_LF_MAX);
  wire [7:0]  bf_lvl    = clamp8(ul_lvl_reg[15:8], `DFM_BF_MIN, `DFM_BF_MAX);
  wire [7:0]  db_limit  = clamp8(encbrk_reg[23:16], 8'h00, `DFM_DUTY_MAX);
  wire [15:0] ulw_lim   = (ulw_dly_reg > `DFM_DLY_MAX) ? `DFM_DLY_MAX : ulw_dly_reg;
  wire [15:0] ult_lim   = (ult_dly_reg > `DFM_DLY_MAX) ? `DFM_DLY_MAX : ult_dly_reg;
  wire        enc_ok    = enc_ok_s_reg[1];
  wire        enc_mod   = enc_mod_s_reg[1];
  wire        fan_err   = fan_s_reg[1];
  wire        tripped   = (TRIP_CODE != 4'h0);

  // threshold: heavy duty is flat, normal duty uses the low level
  // below twice slip. A step, not a curve, keeps the datapath divider free.
  wire [7:0] ul_thresh = (!ctrl_reg[`DFM_CTRL_DUTY] && SPEED_MEAS <= freq_reg[31:16]) ?
                         lf_lvl : bf_lvl;
  wire ul_cond = !ctrl_reg[`DFM_CTRL_ESAVE] && (SPEED_MEAS != 16'h0000) &&
                 (LOAD_LEVEL < ul_thresh);
  // overspeed only in the two closed modes
  wire ovs_cond = (mode == `DFM_MODE_SL2 || mode == `DFM_MODE_VECTOR) &&
                  (SPEED_MEAS > ovspd_reg[15:0]);
  wire [15:0] spd_err = (SPEED_MEAS > SPEED_REF) ? SPEED_MEAS - SPEED_REF :
                        SPEED_REF - SPEED_MEAS;
  wire dev_cond = (mode == `DFM_MODE_VECTOR) && ctrl_reg[`DFM_CTRL_DEV_EN] &&
                  (spd_err > spddev_reg[15:0]);
  // encoder checking needs the module present
  wire enc_cond = enc_mod && ctrl_reg[`DFM_CTRL_ENC_EN] && !enc_ok;

  // ----------------------------------------
  // Pin synchronisers and time base
  // ----------------------------------------
  always @(posedge CLK)
  begin
    if (RESET)
    begin
      enc_ok_s_reg  <= 2'h3;
      enc_mod_s_reg <= 2'h0;
      fan_s_reg     <= 2'h0;
      tick_cnt_reg  <= 18'h00000;
      tick_reg      <= 1'b0;
    end
    else if (CE)
    begin
      enc_ok_s_reg  <= {enc_ok_s_reg[0], ENC_LINE_OK};
      enc_mod_s_reg <= {enc_mod_s_reg[0], ENC_MODULE};
      fan_s_reg     <= {fan_s_reg[0], FAN_ERROR};
      tick_reg      <= (tick_cnt_reg == TICK_CYCLES - 18'h00001);
      tick_cnt_reg  <= (tick_cnt_reg == TICK_CYCLES - 18'h00001) ? 18'h00000 :
                       tick_cnt_reg + 18'h00001;
    end
  end

  // ----------------------------------------
  // Persistence timers
  // ----------------------------------------
  always @(posedge CLK)
  begin
    if (RESET)
    begin
      ulw_cnt_reg <= 16'h0000;
      ult_cnt_reg <= 16'h0000;
      ovs_cnt_reg <= 16'h0000;
      dev_cnt_reg <= 16'h0000;
      enc_cnt_reg <= 16'h0000;
    end
    else if (CE)
    begin
      ulw_cnt_reg <= persist(ul_cond, tick_reg, ulw_cnt_reg);
      ult_cnt_reg <= persist(ul_cond, tick_reg, ult_cnt_reg);
      ovs_cnt_reg <= persist(ovs_cond, tick_reg, ovs_cnt_reg);
      dev_cnt_reg <= persist(dev_cond, tick_reg, dev_cnt_reg);
      enc_cnt_reg <= persist(enc_cond, tick_reg, enc_cnt_reg);
    end
  end

  wire ul_warn_now = ul_cond && (ulw_cnt_reg >= ulw_lim);
  wire ul_trip_now = ul_cond && (ult_cnt_reg >= ult_lim) &&
                     (ul_action == `DFM_UL_COAST || ul_action == `DFM_UL_DECEL);
  wire ovs_trip    = ovs_cond && (ovs_cnt_reg >= ovspd_reg[31:16]);
  wire dev_trip    = dev_cond && (dev_cnt_reg >= spddev_reg[31:16]);
  // encoder line lost for the check time
  wire enc_trip    = enc_cond && (enc_cnt_reg >= encbrk_reg[15:0]);
  // fan mode 0 trips, mode 1 warns
  wire fan_trip    = fan_err && !ctrl_reg[`DFM_CTRL_FAN];
  wire fan_warn    = fan_err && ctrl_reg[`DFM_CTRL_FAN];
  wire [3:0] new_code = ovs_trip ? `DFM_TRIP_OVSPD : dev_trip ? `DFM_TRIP_DEV :
                        enc_trip ? `DFM_TRIP_ENC : fan_trip ? `DFM_TRIP_FAN :
                        ul_trip_now ? `DFM_TRIP_UL : 4'h0;

  // ----------------------------------------
  // Braking limiter and duty measurement
  // ----------------------------------------
  wire cycle_end = (RUN_PHASE == PH_ACC) && (phase_prev_reg != PH_ACC) &&
                   (tot_cnt_reg != 16'h0000);
  wire [23:0] trial = ({16'h0000, pct_reg} + 24'h000001) * den_reg;

  always @(posedge CLK)
  begin
    if (RESET)
    begin
      brk_cnt_reg    <= 16'h0000;
      brk_cut_reg    <= 1'b0;
      dec_cnt_reg    <= 16'h0000;
      tot_cnt_reg    <= 16'h0000;
      phase_prev_reg <= PH_STOP;
      num_reg        <= 24'h000000;
      den_reg        <= 24'h000000;
      pct_reg        <= 8'h00;
      duty_reg       <= 8'h00;
      div_busy_reg   <= 1'b0;
      dbw_reg        <= 1'b0;
    end
    else if (CE)
    begin
      phase_prev_reg <= RUN_PHASE;
      // cut braking after fifteen seconds without pause
      brk_cnt_reg <= persist(BRAKE_REQ, tick_reg, brk_cnt_reg);
      brk_cut_reg <= BRAKE_REQ && (brk_cnt_reg >= `DFM_BRAKE_TICKS);
      // cycle totals, closed when a new acceleration begins
      if (cycle_end)
      begin
        num_reg      <= {8'h00, dec_cnt_reg} * 24'd100;
        den_reg      <= {8'h00, tot_cnt_reg};
        pct_reg      <= 8'h00;
        div_busy_reg <= 1'b1;
        dec_cnt_reg  <= 16'h0000;
        tot_cnt_reg  <= 16'h0000;
      end
      else if (tick_reg && tot_cnt_reg != 16'hffff)
      begin
        tot_cnt_reg <= tot_cnt_reg + 16'h0001;
        if (RUN_PHASE == PH_DEC)
          dec_cnt_reg <= dec_cnt_reg + 16'h0001;
      end
      // percent by repeated trial, at most 101 cycles per result
      if (div_busy_reg && !cycle_end)
      begin
        if (trial <= num_reg && pct_reg != 8'd100)
          pct_reg <= pct_reg + 8'h01;
        else
        begin
          div_busy_reg <= 1'b0;
          duty_reg     <= pct_reg;
          // warn when last cycle's duty is over the limit
          dbw_reg      <= (pct_reg > db_limit);
        end
      end
    end
  end

  // ----------------------------------------
  // Trip latch and outputs
  // ----------------------------------------
  wire trip_clr = aw_ok_reg && w_ok_reg && !S_AXI_BVALID &&
                  aw_addr_reg == `DFM_OFS_TRIP && wstrb_reg[0] && wdata_reg[0];

  always @(posedge CLK)
  begin
    if (RESET)
    begin
      TRIP_CODE  <= 4'h0;
      OUT_BLOCK  <= 1'b0;
      DECEL_STOP <= 1'b0;
      BRAKE_OUT  <= 1'b0;
      RELAY1     <= 1'b0;
      RELAY2     <= 1'b0;
      OC_Q1      <= 1'b0;
      ulw_reg    <= 1'b0;
      IRQ        <= 1'b0;
    end
    else if (CE)
    begin
      // First trip holds until cleared; a pending trip beats the clear
      if (!tripped || trip_clr)
        TRIP_CODE <= new_code;
      // underload decel action, all other trips coast
      if (!tripped || trip_clr)
      begin
        OUT_BLOCK  <= (new_code != 4'h0) &&
                      !(new_code == `DFM_TRIP_UL && ul_action == `DFM_UL_DECEL);
        DECEL_STOP <= (new_code == `DFM_TRIP_UL) && (ul_action == `DFM_UL_DECEL);
      end
      BRAKE_OUT <= BRAKE_REQ && !brk_cut_reg &&
                   !(BRAKE_REQ && brk_cnt_reg >= `DFM_BRAKE_TICKS);
      ulw_reg <= ul_warn_now && ctrl_reg[`DFM_CTRL_ULW_EN];
      RELAY1 <= sel_out(outsel_reg[4:0], ulw_reg, fan_warn, dbw_reg);
      RELAY2 <= sel_out(outsel_reg[12:8], ulw_reg, fan_warn, dbw_reg);
      OC_Q1  <= sel_out(outsel_reg[20:16], ulw_reg, fan_warn, dbw_reg);
      IRQ    <= |(status_reg & mask_reg);
    end
  end

  // ----------------------------------------
  // AXI4-Lite write path and configuration
  // ----------------------------------------
  // Events: warning, trip, brake cut, duty warning, fan error
  wire [4:0] events = {fan_err, dbw_reg, brk_cut_reg, tripped, ulw_reg};
  wire       wr_go  = aw_ok_reg && w_ok_reg && !S_AXI_BVALID;

  always @(posedge CLK)
  begin
    if (RESET)
    begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= 2'h0;
      aw_ok_reg     <= 1'b0;
      w_ok_reg      <= 1'b0;
      aw_addr_reg   <= 8'h00;
      wdata_reg     <= 32'h00000000;
      wstrb_reg     <= 4'h0;
      ctrl_reg      <= `DFM_RST_CTRL;
      ulw_dly_reg   <= `DFM_RST_ULWDLY;
      ult_dly_reg   <= `DFM_RST_ULTDLY;
      ul_lvl_reg    <= `DFM_RST_ULLVL;
      ovspd_reg     <= `DFM_RST_OVSPD;
      spddev_reg    <= `DFM_RST_SPDDEV;
      encbrk_reg    <= `DFM_RST_ENCBRK;
      outsel_reg    <= `DFM_RST_OUTSEL;
      freq_reg      <= `DFM_RST_FREQ;
      status_reg    <= 5'h00;
      mask_reg      <= 5'h00;
    end
    else if (CE)
    begin
      // One-cycle ready pulses take each channel independently
      S_AXI_AWREADY <= !aw_ok_reg && !S_AXI_AWREADY && S_AXI_AWVALID;
      S_AXI_WREADY  <= !w_ok_reg && !S_AXI_WREADY && S_AXI_WVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_ok_reg   <= 1'b1;
        aw_addr_reg <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_ok_reg  <= 1'b1;
        wdata_reg <= S_AXI_WDATA;
        wstrb_reg <= S_AXI_WSTRB;
      end
      if (S_AXI_BVALID && S_AXI_BREADY)
      begin
        S_AXI_BVALID <= 1'b0;
        aw_ok_reg    <= 1'b0;
        w_ok_reg     <= 1'b0;
      end
      // Sticky status: a new event wins over a one-write clear
      status_reg <= events | (status_reg &
                    ~((wr_go && aw_addr_reg == `DFM_OFS_STATUS && wstrb_reg[0]) ?
                      wdata_reg[4:0] : 5'h00));
      if (wr_go)
      begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= (aw_addr_reg > `DFM_OFS_TRIP || aw_addr_reg[1:0] != 2'h0) ?
                        2'h2 : 2'h0;
        // Full-word writes only; partial strobes leave the register alone
        if (wstrb_reg == 4'hf)
          case (aw_addr_reg)
            `DFM_OFS_CTRL:   ctrl_reg    <= wdata_reg;
            `DFM_OFS_ULWDLY: ulw_dly_reg <= wdata_reg[15:0];
            `DFM_OFS_ULTDLY: ult_dly_reg <= wdata_reg[15:0];
            `DFM_OFS_ULLVL:  ul_lvl_reg  <= wdata_reg[15:0];
            `DFM_OFS_OVSPD:  ovspd_reg   <= wdata_reg;
            `DFM_OFS_SPDDEV: spddev_reg  <= wdata_reg;
            `DFM_OFS_ENCBRK: encbrk_reg  <= wdata_reg;
            `DFM_OFS_OUTSEL: outsel_reg  <= wdata_reg[23:0];
            `DFM_OFS_FREQ:   freq_reg    <= wdata_reg;
            `DFM_OFS_MASK:   mask_reg    <= wdata_reg[4:0];
            default:         ;
          endcase
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------
  always @(posedge CLK)
  begin
    if (RESET)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h00000000;
      S_AXI_RRESP   <= 2'h0;
    end
    else if (CE)
    begin
      S_AXI_ARREADY <= !S_AXI_RVALID && !S_AXI_ARREADY && S_AXI_ARVALID;
      if (S_AXI_RVALID && S_AXI_RREADY)
        S_AXI_RVALID <= 1'b0;
      if (S_AXI_ARVALID && S_AXI_ARREADY)
      begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP  <= 2'h0;
        case (S_AXI_ARADDR)
          `DFM_OFS_CTRL:   S_AXI_RDATA <= ctrl_reg;
          `DFM_OFS_ULWDLY: S_AXI_RDATA <= {16'h0000, ulw_dly_reg};
          `DFM_OFS_ULTDLY: S_AXI_RDATA <= {16'h0000, ult_dly_reg};
          `DFM_OFS_ULLVL:  S_AXI_RDATA <= {16'h0000, ul_lvl_reg};
          `DFM_OFS_OVSPD:  S_AXI_RDATA <= ovspd_reg;
          `DFM_OFS_SPDDEV: S_AXI_RDATA <= spddev_reg;
          `DFM_OFS_ENCBRK: S_AXI_RDATA <= encbrk_reg;
          `DFM_OFS_OUTSEL: S_AXI_RDATA <= {8'h00, outsel_reg};
          `DFM_OFS_FREQ:   S_AXI_RDATA <= freq_reg;
          `DFM_OFS_STATUS: S_AXI_RDATA <= {27'h0000000, status_reg};
          `DFM_OFS_MASK:   S_AXI_RDATA <= {27'h0000000, mask_reg};
          `DFM_OFS_TRIP:   S_AXI_RDATA <= {12'h000, fan_warn, ulw_reg, dbw_reg,
                                           enc_mod, duty_reg, 4'h0, TRIP_CODE};
          default:
          begin
            S_AXI_RDATA <= 32'h00000000;
            S_AXI_RRESP <= 2'h2;
          end
        endcase
      end
    end
  end

endmodule // dfm_monitor
`default_nettype wire

// [dv/dfm_monitor_checker.sv]
// Port-level assertions for the drive fault monitor
`timescale 1ns/1ps
`default_nettype none
module dfm_monitor_checker #(
  parameter [17:0] TICK_CYCLES = 18'd10
) (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RESET,
  // Bus answers
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic [31:0] S_AXI_RDATA,
  // Protection side
  input wire logic        BRAKE_REQ,
  input wire logic        ENC_MODULE,
  input wire logic        BRAKE_OUT,
  input wire logic        OUT_BLOCK,
  input wire logic        DECEL_STOP,
  input wire logic [3:0]  TRIP_CODE,
  input wire logic        IRQ
);
  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  logic [31:0] brake_run;
  // Length of the current braking run; tick phase gives one tick of slack
  always_ff @(posedge CLK)
    if (RESET || !BRAKE_OUT) brake_run <= 32'h0;
    else brake_run <= brake_run + 32'h1;
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_bvalid_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
    else $error("write answer dropped early");
  a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read answer changed early");
  a_brake_cap: assert property (brake_run <= 1501 * TICK_CYCLES + 2)
    else $error("braking run too long");
  a_brake_cause: assert property ($rose(BRAKE_OUT) |-> $past(BRAKE_REQ))
    else $error("braking driven without request");
  a_stop_single: assert property (!(OUT_BLOCK && DECEL_STOP))
    else $error("coast and decelerate both requested");
  a_stop_reason: assert property (OUT_BLOCK || DECEL_STOP |-> TRIP_CODE != 4'h0)
    else $error("stop request without trip code");
  a_enc_absent: assert property (!ENC_MODULE [*6] |=>
    !(TRIP_CODE == 4'h4 && $past(TRIP_CODE) != 4'h4)) else $error("encoder trip while absent");
  a_reset_quiet: assert property ($fell(RESET) |-> !OUT_BLOCK && !DECEL_STOP && !IRQ
    && !BRAKE_OUT && TRIP_CODE == 4'h0) else $error("outputs active after reset");
  // Main scenarios reached
  c_block: cover property ($rose(OUT_BLOCK));
  c_decel: cover property ($rose(DECEL_STOP));
  c_cut: cover property ($fell(BRAKE_OUT) && BRAKE_REQ);
  c_irq: cover property ($rose(IRQ));
endmodule // dfm_monitor_checker

bind dfm_monitor dfm_monitor_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.CLK(CLK),
  .RESET(RESET), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_RDATA(S_AXI_RDATA),
  .BRAKE_REQ(BRAKE_REQ), .ENC_MODULE(ENC_MODULE), .BRAKE_OUT(BRAKE_OUT),
  .OUT_BLOCK(OUT_BLOCK), .DECEL_STOP(DECEL_STOP), .TRIP_CODE(TRIP_CODE), .IRQ(IRQ));
`default_nettype wire

// [dv/dfm_plant.sv]
// Encoder option and cooling fan stand-in
`timescale 1ns/1ps
`default_nettype none
module dfm_plant (
  // Clock
  input  wire logic clk,
  // Bench commands
  input  wire logic enc_fit,
  input  wire logic enc_cut,
  input  wire logic fan_bad,
  // Pins towards the monitor
  output var  logic enc_present,
  output var  logic enc_line_ok,
  output var  logic fan_error
);
  // Pins change off-edge like real wiring; the monitor syncs them
  always @(negedge clk)
  begin
    enc_present <= enc_fit;
    enc_line_ok <= enc_fit && !enc_cut;
    fan_error   <= fan_bad;
  end
endmodule // dfm_plant
`default_nettype wire

// [dv/tb_drive_fault_monitor.sv]
// Self-checking bench for the drive fault monitor
`timescale 1ns/1ps
`default_nettype none
module tb_drive_fault_monitor;
  localparam int TC = 10;
  logic clk = 0, rst = 1, awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0;
  logic [7:0] awa = 0, ara = 0, load = 8'd50;
  logic [31:0] wd = 0, rdv, rdata;
  logic [15:0] spd = 16'd100, sref = 16'd100;
  logic brk = 0, fit = 1, cut = 0, fan = 0, awr, wr_r, bv, arr, rv, eok, emod, ferr;
  logic bo, ob, ds, r1, r2, q1, irq;
  logic [1:0] bresp, rresp, rsp, ph = 2'h2;
  logic [3:0] tc;
  int err_total = 0, n_compared = 0;
  // Free-running 20 MHz clock
  always #25 clk = ~clk;
  dfm_plant i_plant (.clk(clk), .enc_fit(fit), .enc_cut(cut), .fan_bad(fan),
    .enc_present(emod), .enc_line_ok(eok), .fan_error(ferr));
  dfm_monitor #(.TICK_CYCLES(18'd10)) i_dut (.CLK(clk), .RESET(rst), .CE(1'b1),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_r), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(brdy), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rrdy), .SPEED_MEAS(spd), .SPEED_REF(sref), .LOAD_LEVEL(load),
    .RUN_PHASE(ph), .BRAKE_REQ(brk), .ENC_LINE_OK(eok), .ENC_MODULE(emod),
    .FAN_ERROR(ferr), .BRAKE_OUT(bo), .OUT_BLOCK(ob), .DECEL_STOP(ds), .TRIP_CODE(tc),
    .RELAY1(r1), .RELAY2(r2), .OC_Q1(q1), .IRQ(irq));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic close_out;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  // Bounded bus waits; a wait that runs out ends the run
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    awa <= a; wd <= d; awv <= 1; wv <= 1; brdy <= 1;
    for (i = 0; i < 50 && !bv; i++)
    begin
      @(posedge clk);
      if (awr) awv <= 0;
      if (wr_r) wv <= 0;
    end
    rsp = bresp;
    brdy <= 0;
    if (i >= 50) chk("bvalid", bv, 1);
    if (i >= 50) close_out;
  endtask
  task automatic rd(input logic [7:0] a);
    int i;
    @(posedge clk);
    ara <= a; arv <= 1; rrdy <= 1;
    for (i = 0; i < 50 && !rv; i++)
    begin
      @(posedge clk);
      if (arr) arv <= 0;
    end
    rdv = rdata; rsp = rresp;
    rrdy <= 0;
    if (i >= 50) chk("rvalid", rv, 1);
    if (i >= 50) close_out;
  endtask
  function automatic logic [3:0] pick(input int w);
    case (w)
      0: pick = r1;  1: pick = r2;  2: pick = irq;  3: pick = bo;
      4: pick = ob;  5: pick = ds;  7: pick = q1;  default: pick = tc;
    endcase
  endfunction
  task automatic wait_on(input string n, input int w, input logic [3:0] v, input int lim);
    for (int i = 0; i < lim && pick(w) !== v; i++) @(posedge clk);
    chk(n, pick(w), v);
    if (pick(w) !== v) close_out;
  endtask
  task automatic clr;
    wr(8'h2c, 32'h1);
    wait_on("trip_clear", 6, 4'h0, 40);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    rd(8'h00); chk("ctrl_rst", rdv, 32'h0010_0019);
    rd(8'h18); chk("encbrk_rst", rdv, 32'h000a_0064);
    rd(8'h10); chk("ovspd_rst", rdv, 32'h0001_2ee0);
    rd(8'h30); chk("rd_unmapped", rsp, 2'h2);
    wr(8'h30, 32'h1); chk("wr_unmapped", rsp, 2'h2);
  endtask
  task automatic t_ovspd;
    for (int k = 0; k < 3; k++)
    begin
      wr(8'h00, 32'h0010_0011 | (k == 0 ? 0 : (k + 2) << 8));
      spd <= 16'd13000;
      repeat (100) @(posedge clk);
      chk("ovspd_code", tc, k == 0 ? 4'h0 : 4'h2);
      chk("ovspd_block", ob, k != 0);
      spd <= 16'd100;
      if (k != 0) clr;
    end
  endtask
  task automatic t_dev;
    wr(8'h14, 32'h0002_07d0); wr(8'h00, 32'h0010_0419); sref <= 16'd3000;
    wait_on("dev_trip", 6, 4'h3, 60);
    sref <= 16'd100; clr;
  endtask
  task automatic t_duty;
    ph <= 2'h1; repeat (100) @(posedge clk); ph <= 2'h3; repeat (100) @(posedge clk);
    ph <= 2'h1; wait_on("duty_warn", 7, 4'h1, 150);
    rd(8'h2c); chk("duty_pct", rdv[15:8] > 49 && rdv[15:8] < 53, 1);
  endtask
  task automatic t_uload;
    wr(8'h04, 32'h2); wr(8'h08, 32'h6);
    repeat (10)
    begin
      load <= 8'd5; repeat (9) @(posedge clk);
      load <= 8'd50; @(posedge clk);
    end
    chk("ul_restart", r1, 1'b0);
    load <= 8'd5;
    wait_on("ul_warn", 0, 4'h1, 60);
    wait_on("ul_trip", 6, 4'h1, 80);
    chk("ul_coast", ob, 1'b1);
    load <= 8'd50; clr;
    wr(8'h00, 32'h0020_0411); load <= 8'd5;
    wait_on("ul_decel", 5, 4'h1, 120);
    load <= 8'd50; clr;
    wr(8'h00, 32'h0010_0415); load <= 8'd5;
    repeat (150) @(posedge clk);
    chk("esave_warn", r1, 1'b0);
    chk("esave_trip", tc, 4'h0);
    load <= 8'd50; wr(8'h00, 32'h0010_0411);
  endtask
  task automatic t_enc;
    cut <= 1; wait_on("enc_trip", 6, 4'h4, 1200);
    cut <= 0; clr;
    fit <= 0; cut <= 1; repeat (1200) @(posedge clk);
    chk("enc_absent", tc, 4'h0);
    fit <= 1; cut <= 0;
  endtask
  task automatic t_fan;
    wr(8'h28, 32'h10); wr(8'h00, 32'h0010_0431); fan <= 1;
    wait_on("fan_warn", 1, 4'h1, 20);
    chk("fan_no_trip", tc, 4'h0);
    wait_on("irq_on", 2, 4'h1, 20);
    fan <= 0; wr(8'h24, 32'h10);
    wait_on("irq_off", 2, 4'h0, 20);
    wr(8'h00, 32'h0010_0411); fan <= 1;
    wait_on("fan_trip", 6, 4'h5, 20);
    chk("fan_block", ob, 1'b1);
    fan <= 0; clr;
  endtask
  task automatic t_brake;
    int n;
    brk <= 1; wait_on("brk_on", 3, 4'h1, 10);
    for (n = 0; n < 16000 && bo; n++) @(posedge clk);
    chk("brk_len", n >= 1499 * TC, 1);
    chk("brk_off", bo, 1'b0);
    brk <= 0;
  endtask
  // Reset, then the scenarios in turn
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    t_regs; t_ovspd; t_dev; t_uload; t_enc; t_fan; t_duty; t_brake;
    close_out;
  end
endmodule // tb_drive_fault_monitor
`default_nettype wire
